// [hdl/mrd_pkg.sv]
// Notes on behaviour
// - Request descriptor when needed, load returned address
// - Descriptor machine leaves idle when receive run low
// - Descriptor read starts only on fetch grant
// - Owned descriptor word moves to wait state
// - Unowned descriptor word suspends the descriptor machine
// - Wait returns to main on read done
// - Suspended machine resumes on MAC poll or demand
// - Data machine leaves idle only on grant
// - Descriptor words read until word count two
// - Invalid descriptor in pause returns to idle
// - Valid descriptor plus grant starts burst unless starved
// - Complete frame after last burst goes to status
// - Full buffer goes to write-back unless chained second
// - Otherwise return to pause before next burst
// - Status waits for non-empty receive FIFO
// - Write-back ends on grant and valid response
// - CRC and pad marks valid only at start
// - Report transmit jabber timeout to status register
// - Auto poll period bits, enabled by enable bit
// - Bursts never exceed configured burst limit, except a zero limit gives one-word bursts
// - Descriptor address advances by configured offset
// - Pulse missed-frame bump when no buffer available
package mrd_pkg;
    localparam int DESC_OWN_BIT = 31;
    localparam int DESC_CHAIN_BIT = 24;
    localparam int DESC_SIZE2_HI = 21;
    localparam int DESC_SIZE2_LO = 11;
    localparam int DESC_SIZE1_HI = 10;
    localparam int DESC_WORDS_LAST = 2;
    localparam logic [1:0] CMD_IDLE = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        MRD_DS_IDLE = 3'h0,
        MRD_DS_MAIN = 3'h1,
        MRD_DS_READ = 3'h3,
        MRD_DS_WAIT = 3'h2,
        MRD_DS_SUSP = 3'h6
    } mrd_ds_state_t;

    typedef enum logic [2:0] {
        MRD_RX_IDLE = 3'h0,
        MRD_RX_READ_DS = 3'h1,
        MRD_RX_PAUSE = 3'h3,
        MRD_RX_WRITE = 3'h2,
        MRD_RX_STAT = 3'h6,
        MRD_RX_WB = 3'h7
    } mrd_rx_state_t;
endpackage

// [hdl/mrd_autopoll.sv]
`timescale 1ns/1ps
module mrd_autopoll (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sw_reset,
    // Poll setup
    input wire logic tx_autopoll_enable,
    input wire logic [15:0] tx_autopoll_period,
    // Poll tick
    output logic poll_tick
);
    logic [15:0] cnt_r;
    logic hit;

    // Period reached; a zero period ticks every cycle
    assign hit = tx_autopoll_enable && (cnt_r >= tx_autopoll_period);

    // Counter only runs while polling is enabled
    always_ff @(posedge sys_clk)
    begin
        if (rst || sw_reset || !tx_autopoll_enable || hit)
        begin
            cnt_r <= 16'h0000;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || sw_reset)
        begin
            poll_tick <= 1'b0;
        end
        else
        begin
            poll_tick <= hit;
        end
    end

    autopoll_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        !tx_autopoll_enable ##1 !tx_autopoll_enable |-> !poll_tick)
        else $error("auto poll tick while disabled");
endmodule

// [hdl/mrd_txmarks.sv]
`timescale 1ns/1ps
module mrd_txmarks (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Transmit word marks in
    input wire logic tx_word_sof,
    input wire logic tx_checksum_req,
    input wire logic tx_pad_req,
    // Marks toward transmit FIFO
    output logic tx_append_checksum,
    output logic tx_append_pad
);
    // Marks are forced low off the first word so the FIFO never sees stale ones
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_append_checksum <= 1'b0;
            tx_append_pad <= 1'b0;
        end
        else
        begin
            tx_append_checksum <= tx_word_sof && tx_checksum_req;
            tx_append_pad <= tx_word_sof && tx_pad_req;
        end
    end

    marks_sof_a: assert property (@(posedge sys_clk) disable iff (rst)
        !tx_word_sof |=> !tx_append_checksum && !tx_append_pad)
        else $error("tx marks outside start of frame");
endmodule

// [hdl/mrd_top.sv]
`timescale 1ns/1ps
module mrd_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sw_reset,
    // Control inputs
    input wire logic receive_run_control,
    input wire logic receive_poll_demand,
    input wire logic mac_desc_poll_request,
    input wire logic [5:0] burst_length_limit,
    input wire logic [4:0] desc_step_offset,
    input wire logic [31:0] desc_base,
    // Arbiter grants and descriptor pointer return
    input wire logic desc_fetch_grant,
    input wire logic rx_data_grant,
    input wire logic desc_wanted,
    input wire logic arbiter_desc_valid,
    input wire logic [31:0] arbiter_desc_word,
    // Host response
    input wire logic host_response_valid,
    input wire logic [31:0] host_response_word,
    input wire logic host_response_error,
    // Receive FIFO
    input wire logic rx_fifo_is_empty,
    input wire logic rx_fifo_final_read,
    input wire logic [31:0] rx_fifo_word,
    input wire logic rx_fifo_eof,
    input wire logic rx_frame_dropped,
    // Transmit side inputs
    input wire logic tx_word_sof,
    input wire logic tx_checksum_req,
    input wire logic tx_pad_req,
    input wire logic tx_jabber_event,
    input wire logic tx_autopoll_enable,
    input wire logic [15:0] tx_autopoll_period,
    // Host bus command
    output logic [1:0] host_cmd,
    output logic [31:0] host_addr,
    output logic [31:0] host_wdata,
    output logic host_last,
    output logic rx_fifo_read,
    // Descriptor fetch handshake
    output logic desc_fetch_request,
    output logic [31:0] active_desc_pointer,
    // Status toward registers
    output logic [2:0] rx_desc_state,
    output logic rx_suspended,
    output logic rx_bus_error,
    output logic missed_frame_bump,
    output logic tx_jabber_timeout_flag,
    output logic tx_poll_tick,
    output logic tx_append_checksum,
    output logic tx_append_pad
);
    mrd_pkg::mrd_ds_state_t ds_r, ds_nxt;
    mrd_pkg::mrd_rx_state_t rx_r, rx_nxt;
    logic [31:0] desc_ctrl_r;
    logic [31:0] buf_addr_r;
    logic [1:0] dw_cnt_r;
    logic [5:0] burst_cnt_r;
    logic [10:0] buf_cnt_r;
    logic frame_done_r;
    logic cur_desc_ok_r;
    logic desc_read_done_r;
    logic clr;
    logic ds_own;
    logic chained_second;
    logic burst_end;
    logic buf_full;
    logic starved;
    logic in_write;
    logic word_go;
    logic rd_go;
    logic [1:0] rd_idx;
    logic wr_end;
    logic [10:0] buf_size;
    logic [5:0] burst_max;
    logic [31:0] next_ptr;

    assign clr = rst || sw_reset;
    assign ds_own = host_response_word[mrd_pkg::DESC_OWN_BIT];
    // Second buffer is chained when bit set and size field nonzero
    assign chained_second = desc_ctrl_r[mrd_pkg::DESC_CHAIN_BIT] &&
        (desc_ctrl_r[mrd_pkg::DESC_SIZE2_HI:mrd_pkg::DESC_SIZE2_LO] != 11'h000);
    assign buf_size = desc_ctrl_r[mrd_pkg::DESC_SIZE1_HI:0];
    // A zero limit still moves one word per burst to avoid a stall
    assign burst_max = (burst_length_limit == 6'h00) ? 6'h01 : burst_length_limit;
    assign buf_full = (buf_cnt_r >= buf_size);
    assign starved = rx_fifo_is_empty && !rx_fifo_final_read && !host_last;
    assign in_write = (rx_r == mrd_pkg::MRD_RX_WRITE);
    // FIFO pops on the edge after the read pulse, so words go every other cycle
    assign word_go = in_write && !rx_fifo_is_empty && !host_last && !frame_done_r && !rx_fifo_read;
    // One descriptor word read at a time, the next only after its answer
    assign rd_go = (rx_r == mrd_pkg::MRD_RX_IDLE && rx_data_grant) || (rx_r == mrd_pkg::MRD_RX_READ_DS &&
        host_response_valid && dw_cnt_r != 2'(mrd_pkg::DESC_WORDS_LAST));
    assign rd_idx = (rx_r == mrd_pkg::MRD_RX_READ_DS) ? dw_cnt_r + 2'h1 : 2'h0;
    assign burst_end = (burst_cnt_r + 6'h01 >= burst_max) || rx_fifo_eof ||
        (buf_cnt_r + 11'h001 >= buf_size);
    assign wr_end = in_write && host_last && !host_response_valid;
    assign next_ptr = active_desc_pointer + {27'h0, desc_step_offset};

    // Descriptor machine next state
    always_comb
    begin
        ds_nxt = ds_r;
        case (ds_r)
            mrd_pkg::MRD_DS_IDLE:
                if (!receive_run_control) ds_nxt = mrd_pkg::MRD_DS_MAIN;
            mrd_pkg::MRD_DS_MAIN:
                if (desc_fetch_grant) ds_nxt = mrd_pkg::MRD_DS_READ;
            mrd_pkg::MRD_DS_READ:
                if (host_response_valid)
                    ds_nxt = ds_own ? mrd_pkg::MRD_DS_WAIT : mrd_pkg::MRD_DS_SUSP;
            mrd_pkg::MRD_DS_WAIT:
                if (desc_read_done_r) ds_nxt = mrd_pkg::MRD_DS_MAIN;
            mrd_pkg::MRD_DS_SUSP:
                if (mac_desc_poll_request || receive_poll_demand) ds_nxt = mrd_pkg::MRD_DS_MAIN;
            default:
                ds_nxt = mrd_pkg::MRD_DS_IDLE;
        endcase
    end

    // Data machine next state
    always_comb
    begin
        rx_nxt = rx_r;
        case (rx_r)
            mrd_pkg::MRD_RX_IDLE:
                if (rx_data_grant) rx_nxt = mrd_pkg::MRD_RX_READ_DS;
            mrd_pkg::MRD_RX_READ_DS:
                if (host_response_valid && dw_cnt_r == 2'(mrd_pkg::DESC_WORDS_LAST))
                    rx_nxt = mrd_pkg::MRD_RX_PAUSE;
            mrd_pkg::MRD_RX_PAUSE:
                if (!cur_desc_ok_r) rx_nxt = mrd_pkg::MRD_RX_IDLE;
                else if (!starved && rx_data_grant) rx_nxt = mrd_pkg::MRD_RX_WRITE;
            mrd_pkg::MRD_RX_WRITE:
                if (wr_end)
                begin
                    if (frame_done_r) rx_nxt = mrd_pkg::MRD_RX_STAT;
                    else if (buf_full && !chained_second) rx_nxt = mrd_pkg::MRD_RX_WB;
                    else rx_nxt = mrd_pkg::MRD_RX_PAUSE;
                end
            mrd_pkg::MRD_RX_STAT:
                if (!rx_fifo_is_empty) rx_nxt = mrd_pkg::MRD_RX_WB;
            mrd_pkg::MRD_RX_WB:
                if (rx_data_grant && host_response_valid) rx_nxt = mrd_pkg::MRD_RX_IDLE;
            default:
                rx_nxt = mrd_pkg::MRD_RX_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            ds_r <= mrd_pkg::MRD_DS_IDLE;
            rx_r <= mrd_pkg::MRD_RX_IDLE;
        end
        else
        begin
            ds_r <= ds_nxt;
            rx_r <= rx_nxt;
        end
    end

    // Descriptor pointer fetch handshake
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            desc_fetch_request <= 1'b0;
            active_desc_pointer <= mrd_pkg::PTR_RESET;
        end
        else if (desc_fetch_request && arbiter_desc_valid)
        begin
            desc_fetch_request <= 1'b0;
            active_desc_pointer <= arbiter_desc_word;
        end
        else if (desc_wanted)
        begin
            desc_fetch_request <= 1'b1;
        end
        else if (rx_r == mrd_pkg::MRD_RX_WB && rx_nxt == mrd_pkg::MRD_RX_IDLE)
        begin
            active_desc_pointer <= next_ptr;
        end
    end

    // Descriptor word capture and counters
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            dw_cnt_r <= 2'h0;
            desc_ctrl_r <= 32'h0;
            buf_addr_r <= 32'h0;
            cur_desc_ok_r <= 1'b0;
            desc_read_done_r <= 1'b0;
        end
        else
        begin
            desc_read_done_r <= (rx_r == mrd_pkg::MRD_RX_READ_DS) && (rx_nxt == mrd_pkg::MRD_RX_PAUSE);
            if (rx_r == mrd_pkg::MRD_RX_IDLE)
            begin
                dw_cnt_r <= 2'h0;
            end
            else if (rx_r == mrd_pkg::MRD_RX_READ_DS && host_response_valid)
            begin
                dw_cnt_r <= dw_cnt_r + 2'h1;
                if (dw_cnt_r == 2'h0) cur_desc_ok_r <= ds_own && !host_response_error;
                if (dw_cnt_r == 2'h1) desc_ctrl_r <= host_response_word;
                if (dw_cnt_r == 2'h2) buf_addr_r <= host_response_word;
            end
            else if (host_response_error)
            begin
                cur_desc_ok_r <= 1'b0;
            end
        end
    end

    // Burst data mover; at most one word every other cycle
    always_ff @(posedge sys_clk)
    begin
        if (clr || rx_r == mrd_pkg::MRD_RX_READ_DS)
        begin
            burst_cnt_r <= 6'h00;
            buf_cnt_r <= 11'h000;
            frame_done_r <= 1'b0;
            host_last <= 1'b0;
        end
        else if (word_go)
        begin
            burst_cnt_r <= burst_cnt_r + 6'h01;
            buf_cnt_r <= buf_cnt_r + 11'h001;
            frame_done_r <= rx_fifo_eof;
            host_last <= burst_end;
        end
        else if (rx_r == mrd_pkg::MRD_RX_PAUSE)
        begin
            burst_cnt_r <= 6'h00;
            host_last <= 1'b0;
        end
        else if (wr_end)
        begin
            host_last <= 1'b0;
        end
    end

    // Host command drive
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            host_cmd <= mrd_pkg::CMD_IDLE;
            host_addr <= 32'h0;
            host_wdata <= 32'h0;
            rx_fifo_read <= 1'b0;
        end
        else
        begin
            rx_fifo_read <= word_go || (rx_r == mrd_pkg::MRD_RX_STAT && !rx_fifo_is_empty);
            if (rd_go)
            begin
                host_cmd <= mrd_pkg::CMD_READ;
                host_addr <= active_desc_pointer + {28'h0, rd_idx, 2'h0};
            end
            else if (ds_r == mrd_pkg::MRD_DS_MAIN && desc_fetch_grant)
            begin
                host_cmd <= mrd_pkg::CMD_READ;
                host_addr <= active_desc_pointer;
            end
            else if (word_go)
            begin
                host_cmd <= mrd_pkg::CMD_WRITE;
                host_addr <= buf_addr_r + {19'h0, buf_cnt_r, 2'h0};
                host_wdata <= rx_fifo_word;
            end
            else if (rx_r == mrd_pkg::MRD_RX_STAT && rx_nxt == mrd_pkg::MRD_RX_WB)
            begin
                host_cmd <= mrd_pkg::CMD_WRITE;
                host_addr <= active_desc_pointer;
                host_wdata <= {1'b0, rx_fifo_word[30:0]};
            end
            else
            begin
                host_cmd <= mrd_pkg::CMD_IDLE;
            end
        end
    end

    // Status outputs; flags set wins over software reset clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rx_desc_state <= 3'h0;
            rx_suspended <= 1'b0;
            rx_bus_error <= 1'b0;
            missed_frame_bump <= 1'b0;
            tx_jabber_timeout_flag <= 1'b0;
        end
        else
        begin
            rx_desc_state <= ds_r;
            rx_suspended <= (ds_r == mrd_pkg::MRD_DS_SUSP);
            rx_bus_error <= host_response_error || (rx_bus_error && !sw_reset);
            missed_frame_bump <= rx_frame_dropped && (ds_r == mrd_pkg::MRD_DS_SUSP);
            tx_jabber_timeout_flag <= tx_jabber_event || (tx_jabber_timeout_flag && !sw_reset);
        end
    end

    mrd_autopoll u_autopoll (
        .sys_clk(sys_clk),
        .rst(rst),
        .sw_reset(sw_reset),
        .tx_autopoll_enable(tx_autopoll_enable),
        .tx_autopoll_period(tx_autopoll_period),
        .poll_tick(tx_poll_tick)
    );

    mrd_txmarks u_txmarks (
        .sys_clk(sys_clk),
        .rst(rst),
        .tx_word_sof(tx_word_sof),
        .tx_checksum_req(tx_checksum_req),
        .tx_pad_req(tx_pad_req),
        .tx_append_checksum(tx_append_checksum),
        .tx_append_pad(tx_append_pad)
    );

    idle_leave_a: assert property (@(posedge sys_clk) disable iff (clr)
        ds_r == mrd_pkg::MRD_DS_IDLE && receive_run_control |=> ds_r == mrd_pkg::MRD_DS_IDLE)
        else $error("descriptor machine left idle while run high");
    fetch_grant_a: assert property (@(posedge sys_clk) disable iff (clr)
        ds_r == mrd_pkg::MRD_DS_MAIN ##1 ds_r == mrd_pkg::MRD_DS_READ |-> $past(desc_fetch_grant))
        else $error("descriptor read without grant");
    own_wait_a: assert property (@(posedge sys_clk) disable iff (clr)
        ds_r == mrd_pkg::MRD_DS_READ && host_response_valid && ds_own |=> ds_r == mrd_pkg::MRD_DS_WAIT)
        else $error("owned descriptor not waited");
    own_susp_a: assert property (@(posedge sys_clk) disable iff (clr)
        ds_r == mrd_pkg::MRD_DS_READ && host_response_valid && !ds_own |=> ds_r == mrd_pkg::MRD_DS_SUSP
        ##1 rx_suspended)
        else $error("unowned descriptor not suspended");
    resume_poll_a: assert property (@(posedge sys_clk) disable iff (clr)
        ds_r == mrd_pkg::MRD_DS_SUSP && (receive_poll_demand || mac_desc_poll_request)
        |=> ds_r == mrd_pkg::MRD_DS_MAIN)
        else $error("suspended machine did not resume");
    ptr_load_a: assert property (@(posedge sys_clk) disable iff (clr)
        desc_fetch_request && arbiter_desc_valid |=> !desc_fetch_request &&
        active_desc_pointer == $past(arbiter_desc_word))
        else $error("descriptor pointer not loaded");
    pause_idle_a: assert property (@(posedge sys_clk) disable iff (clr)
        rx_r == mrd_pkg::MRD_RX_PAUSE && !cur_desc_ok_r |=> rx_r == mrd_pkg::MRD_RX_IDLE)
        else $error("invalid descriptor did not return idle");
    burst_limit_a: assert property (@(posedge sys_clk) disable iff (clr)
        burst_cnt_r <= burst_max)
        else $error("burst exceeded limit");
    stat_wait_a: assert property (@(posedge sys_clk) disable iff (clr)
        rx_r == mrd_pkg::MRD_RX_STAT && rx_fifo_is_empty |=> rx_r == mrd_pkg::MRD_RX_STAT)
        else $error("status left with empty fifo");
    wb_done_a: assert property (@(posedge sys_clk) disable iff (clr)
        rx_r == mrd_pkg::MRD_RX_WB && rx_data_grant && host_response_valid |=> rx_r == mrd_pkg::MRD_RX_IDLE)
        else $error("write-back did not complete");
    jabber_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        tx_jabber_event |=> tx_jabber_timeout_flag)
        else $error("jabber not reported");
endmodule

// [tb/mrd_host_mem.sv]
`timescale 1ns/1ps
module mrd_host_mem (
    // Clock
    input wire logic sys_clk,
    // Command from the block
    input wire logic [1:0] host_cmd,
    input wire logic [31:0] host_addr,
    input wire logic [31:0] host_wdata,
    // Bench control
    input wire logic slow,
    input wire logic fail_next,
    // Response toward the block
    output logic host_response_valid,
    output logic [31:0] host_response_word,
    output logic host_response_error
);
    logic [31:0] mem [logic [31:0]];
    logic [65:0] pend [$];
    logic [65:0] r;
    logic hold = 1'b0;
    // In-order answers; slow mode skips every other cycle
    always @(posedge sys_clk)
    begin
        host_response_valid <= 1'b0;
        host_response_error <= 1'b0;
        host_response_word <= ~host_response_word; // Idle bus never holds the last word
        hold <= slow & ~hold;
        if (host_cmd == mrd_pkg::CMD_WRITE || host_cmd == mrd_pkg::CMD_READ)
            pend.push_back({host_cmd, host_addr, host_wdata});
        if (pend.size() != 0 && !hold)
        begin
            r = pend.pop_front();
            host_response_valid <= 1'b1;
            host_response_error <= fail_next;
            if (r[65:64] == mrd_pkg::CMD_WRITE)
                mem[r[63:32]] = r[31:0];
            else
                host_response_word <= mem.exists(r[63:32]) ? mem[r[63:32]] : 32'h0;
        end
    end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // Design ports
    logic sys_clk, rst, sw_reset, receive_run_control, receive_poll_demand, mac_desc_poll_request;
    logic desc_fetch_grant, rx_data_grant, desc_wanted, arbiter_desc_valid, host_response_valid, host_response_error;
    logic rx_fifo_is_empty, rx_fifo_final_read, rx_fifo_eof, rx_frame_dropped, tx_word_sof, tx_checksum_req;
    logic tx_pad_req, tx_jabber_event, tx_autopoll_enable, host_last, rx_fifo_read, desc_fetch_request;
    logic rx_suspended, rx_bus_error, missed_frame_bump, tx_jabber_timeout_flag, tx_poll_tick;
    logic tx_append_checksum, tx_append_pad, slow, fail_next;
    logic [5:0] burst_length_limit;
    logic [4:0] desc_step_offset;
    logic [31:0] desc_base, arbiter_desc_word, host_response_word, rx_fifo_word, host_addr, host_wdata;
    logic [31:0] active_desc_pointer;
    logic [15:0] tx_autopoll_period;
    logic [1:0] host_cmd;
    logic [2:0] rx_desc_state;
    // Bench state
    logic [32:0] fq [$];
    int error_cnt = 0, check_count = 0, cyc = 0, wr_cnt = 0, bcnt = 0, bmax = 0, k;

    mrd_top dut_u (.*);
    mrd_host_mem mem_u (.*);

    // Clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Receive FIFO model; empty shows a toggling word
    always @(negedge sys_clk)
    begin
        rx_fifo_is_empty <= (fq.size() == 0);
        rx_fifo_final_read <= (fq.size() == 1);
        rx_fifo_word <= (fq.size() != 0) ? fq[0][31:0] : ~rx_fifo_word;
        rx_fifo_eof <= (fq.size() != 0) && fq[0][32];
    end
    // Pops, burst sizes, timeout
    always @(posedge sys_clk)
    begin
        cyc++;
        if (rx_fifo_read === 1'b1 && fq.size() != 0)
            void'(fq.pop_front());
        if (host_cmd === mrd_pkg::CMD_WRITE)
        begin
            wr_cnt++;
            bcnt++;
            if (host_last === 1'b1)
            begin
                bmax = (bcnt > bmax) ? bcnt : bmax;
                bcnt = 0;
            end
        end
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    // Compare and count
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wait_state(logic [2:0] s, string what);
        for (k = 0; k < 300 && rx_desc_state !== s; k++) step(1);
        chk(what, {29'h0, rx_desc_state}, {29'h0, s});
    endtask
    task automatic do_swr();
        sw_reset = 1'b1;
        receive_run_control = 1'b1;
        desc_fetch_grant = 1'b0;
        rx_data_grant = 1'b0;
        step(2);
        sw_reset = 1'b0;
        fq.delete();
        step(1);
    endtask
    // Pointer handshake
    task automatic get_ptr(logic [31:0] p);
        desc_wanted = 1'b1;
        for (k = 0; k < 50 && desc_fetch_request !== 1'b1; k++) step(1);
        desc_wanted = 1'b0;
        arbiter_desc_valid = 1'b1;
        arbiter_desc_word = p;
        step(1);
        arbiter_desc_valid = 1'b0;
        chk("req drop", {31'h0, desc_fetch_request}, 32'h0);
        chk("ptr", active_desc_pointer, p);
    endtask
    // Whole frame
    task automatic run_frame();
        logic [31:0] p, b, st;
        logic [31:0] fr [8];
        int n;
        n = $urandom_range(6, 2);
        p = 32'h0001_0000 + 32'($urandom_range(255, 1)) * 32'h100;
        b = p + 32'h0000_4000;
        st = $urandom;
        burst_length_limit = 6'($urandom_range(4, 1));
        desc_step_offset = 5'($urandom_range(31, 1));
        slow = 1'($urandom);
        mem_u.mem[p] = 32'h8000_0000;
        mem_u.mem[p + 4] = 32'h0000_0040;
        mem_u.mem[p + 8] = b;
        get_ptr(p);
        receive_run_control = 1'b0;
        wait_state(3'h1, "run low");
        step(8);
        chk("no grant state", {29'h0, rx_desc_state}, 32'h1);
        chk("no grant cmd", {30'h0, host_cmd}, 32'h0);
        desc_fetch_grant = 1'b1;
        wait_state(3'h2, "owned");
        desc_fetch_grant = 1'b0;
        for (k = 0; k < n; k++)
        begin
            fr[k] = $urandom;
            fq.push_back({k == n - 1, fr[k]});
        end
        {wr_cnt, bcnt, bmax} = '0;
        rx_data_grant = 1'b1;
        for (k = 0; k < 500 && wr_cnt < n; k++) step(1);
        wait_state(3'h1, "desc read");
        step(10);
        chk("ptr pre status", active_desc_pointer, p);
        fq.push_back({1'b1, st});
        for (k = 0; k < 300 && active_desc_pointer === p; k++) step(1);
        rx_data_grant = 1'b0;
        chk("ptr step", active_desc_pointer, p + 32'(desc_step_offset));
        chk("writeback", mem_u.mem[p], st & 32'h7fff_ffff);
        for (k = 0; k < n; k++) chk("buf word", mem_u.mem[b + 32'(4 * k)], fr[k]);
        chk("burst", 32'(bmax == 0 || bmax > burst_length_limit), 32'h0);
        $display("Test frame %0d done", n);
    endtask
    // Unowned descriptor, suspend, resume
    task automatic run_suspend();
        mem_u.mem[32'h0002_0000] = 32'h0;
        get_ptr(32'h0002_0000);
        fail_next = 1'b1;
        receive_run_control = 1'b0;
        desc_fetch_grant = 1'b1;
        rx_data_grant = 1'b1;
        fq.push_back({1'b1, 32'h1234_5678});
        wr_cnt = 0;
        for (int j = 0; j < 2; j++)
        begin
            wait_state(3'h6, "unowned");
            fail_next = 1'b0;
            step(20);
            chk("susp flag", {31'h0, rx_suspended}, 32'h1);
            chk("no desc writes", 32'(wr_cnt), 32'h0);
            rx_frame_dropped = 1'b1;
            step(1);
            rx_frame_dropped = 1'b0;
            chk("missed", {31'h0, missed_frame_bump}, 32'h1);
            receive_poll_demand = (j == 0);
            mac_desc_poll_request = (j == 1);
            step(1);
            receive_poll_demand = 1'b0;
            mac_desc_poll_request = 1'b0;
            for (k = 0; k < 10 && rx_suspended !== 1'b0; k++) step(1);
            chk("resume", {31'h0, rx_suspended}, 32'h0);
        end
        chk("bus err", {31'h0, rx_bus_error}, 32'h1);
        $display("Test suspend done");
    endtask
    // Transmit side
    task automatic run_tx();
        int t;
        for (k = 0; k < 16; k++)
        begin
            tx_word_sof = 1'b1;
            tx_checksum_req = 1'($urandom);
            tx_pad_req = 1'($urandom);
            step(1);
            chk("checksum mark", {31'h0, tx_append_checksum}, {31'h0, tx_checksum_req});
            chk("pad mark", {31'h0, tx_append_pad}, {31'h0, tx_pad_req});
        end
        tx_word_sof = 1'b0;
        tx_jabber_event = 1'b1;
        step(1);
        tx_jabber_event = 1'b0;
        step(5);
        chk("jabber flag", {31'h0, tx_jabber_timeout_flag}, 32'h1);
        tx_autopoll_period = 16'($urandom_range(6, 2));
        tx_autopoll_enable = 1'b1;
        for (k = 0; k < 20 && tx_poll_tick !== 1'b1; k++) step(1);
        step(1);
        for (k = 1; k < 20 && tx_poll_tick !== 1'b1; k++) step(1);
        chk("poll gap", 32'(k), 32'(tx_autopoll_period) + 32'h1);
        tx_autopoll_enable = 1'b0;
        step(2);
        t = 0;
        repeat (30)
        begin
            t += (tx_poll_tick === 1'b1);
            step(1);
        end
        chk("ticks off", 32'(t), 32'h0);
        $display("Test tx done");
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'h1d86));
        {sw_reset, receive_poll_demand, mac_desc_poll_request, desc_fetch_grant, rx_data_grant} = '0;
        {desc_wanted, arbiter_desc_valid, rx_frame_dropped, tx_word_sof, tx_checksum_req, tx_pad_req} = '0;
        {tx_jabber_event, tx_autopoll_enable, slow, fail_next, rx_fifo_final_read, rx_fifo_eof} = '0;
        {burst_length_limit, desc_step_offset, desc_base, arbiter_desc_word, rx_fifo_word} = '0;
        tx_autopoll_period = 16'h0;
        rx_fifo_is_empty = 1'b1;
        rst = 1'b1;
        receive_run_control = 1'b1;
        step(20);
        rst = 1'b0;
        step(1);
        chk("rst state", {29'h0, rx_desc_state}, 32'h0);
        chk("rst req", {31'h0, desc_fetch_request}, 32'h0);
        chk("rst cmd", {30'h0, host_cmd}, 32'h0);
        arbiter_desc_valid = 1'b1;
        arbiter_desc_word = 32'h0000_5550;
        step(1);
        arbiter_desc_valid = 1'b0;
        step(1);
        chk("stray ptr", active_desc_pointer, 32'h0);
        repeat (2)
        begin
            run_frame();
            do_swr();
        end
        run_tx();
        run_suspend();
        do_swr();
        chk("jabber clr", {31'h0, tx_jabber_timeout_flag}, 32'h0);
        chk("err clr", {31'h0, rx_bus_error}, 32'h0);
        chk("swr state", {29'h0, rx_desc_state}, 32'h0);
        test_done();
    end
endmodule
